/* storage_cmd_regs.vh */
`ifndef STORAGE_CMD_REGS_VH
`define STORAGE_CMD_REGS_VH
// Summary of operation
// [R01] storage is 160 blocks of 4096 bytes
// [R02] serial frames go to cluster 0x23, endpoint 0xe6
// [R03] requester uses explicit frame type 0x11
// [R04] network requests arrive on udp port 0x0bee
// [R05] header: code, option, block, offset, length, payload
// [R06] length counts payload, or bytes wanted on read
// [R07] multi-byte header fields are sent big-endian
// [R08] unicast gets reply to source endpoint; broadcast none
// [R09] explicit reply for endpoint 0xe6 or explicit requester
// [R10] reply echoes code, status replaces option byte
// [R11] geometry query: code 0x00, offset zero, no payload
// [R12] geometry query answered with code 0x80
// [R13] status bit 0 flags error, rest reserved
// [R14] reply gives block count and block size
// [R15] geometry reply has zero length, no payload
// [R16] unknown code gets error reply without payload

// ***************************************************************
// register offsets (apb byte addresses)
// ***************************************************************
`define CTRL_OFS 12'h000
`define STATUS_OFS 12'h004
`define INT_STAT_OFS 12'h008
`define INT_MASK_OFS 12'h00c
`define FRAME_CNT_OFS 12'h010

// ***************************************************************
// register fields and reset values
// ***************************************************************
`define CTRL_ENABLE_BIT 0
`define CTRL_FRAME_MODE_BIT 1
`define CTRL_APP_HDR_LSB 8
`define CTRL_APP_HDR_MSB 15
`define CTRL_RESET 32'h00000003
`define INT_MASK_RESET 5'h00
`define EV_REPLY_DONE 0
`define EV_BAD_CMD 1
`define EV_BCAST_DROP 2
`define EV_ADDR_REJECT 3
`define EV_SHORT_FRAME 4
`define EV_WIDTH 5

// ***************************************************************
// frame constants
// ***************************************************************
`define HDR_BYTES 4'h8
`define STORAGE_CLUSTER 16'h0023
`define VENDOR_ENDPOINT 8'he6
`define STORAGE_UDP_PORT 16'h0bee
`define CMD_GEOMETRY_QUERY 8'h00
`define CMD_GEOMETRY_REPLY 8'h80
`define STORAGE_BLOCK_COUNT 16'h00a0
`define STORAGE_BLOCK_SIZE 16'h1000
`define STATUS_OK 8'h00
`define STATUS_ERROR 8'h01
`endif

/* hdr_capture.v */
`include "storage_cmd_regs.vh"

module hdr_capture (
  // clock and reset
  input wire clk_i,
  input wire nrst_i,
  // set-up
  input wire [7:0] skip_i,
  // request byte stream
  input wire take_i,
  input wire [7:0] byte_i,
  input wire last_i,
  // captured header
  output wire [63:0] hdr_o,
  output reg done_o,
  output reg short_o
);

  reg [63:0] hdr_q;
  reg [8:0] cnt_q;
  wire [8:0] hdr_end;

  // the application header is skipped, then eight bytes shift in msb first
  assign hdr_end = {1'b0, skip_i} + {5'h00, `HDR_BYTES};
  assign hdr_o = hdr_q;

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      hdr_q <= 64'h0000000000000000;
      cnt_q <= 9'h000;
      done_o <= 1'b0;
      short_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (take_i) begin
        if (cnt_q >= {1'b0, skip_i} && cnt_q < hdr_end) begin
          hdr_q <= {hdr_q[55:0], byte_i}; // see [R05] see [R07]
        end
        // payload bytes past the header are counted only up to saturation
        if (last_i) begin
          cnt_q <= 9'h000;
          done_o <= 1'b1;
          short_o <= (cnt_q + 9'h001) < hdr_end;
        end else if (cnt_q != 9'h1ff) begin
          cnt_q <= cnt_q + 9'h001;
        end
      end
    end
  end

endmodule

/* reply_serialiser.v */
module reply_serialiser (
  // clock and reset
  input wire clk_i,
  input wire nrst_i,
  // load side
  input wire load_i,
  input wire [63:0] frame_i,
  output wire busy_o,
  // reply byte stream
  output wire tx_valid_o,
  output wire [7:0] tx_byte_o,
  output wire tx_last_o,
  input wire tx_ready_i
);

  reg [63:0] sh_q;
  reg [2:0] idx_q;
  reg busy_q;

  assign busy_o = busy_q;
  assign tx_valid_o = busy_q;
  assign tx_byte_o = sh_q[63:56];
  assign tx_last_o = busy_q && (idx_q == 3'h7);

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      sh_q <= 64'h0000000000000000;
      idx_q <= 3'h0;
      busy_q <= 1'b0;
    end else if (load_i && !busy_q) begin
      sh_q <= frame_i;
      idx_q <= 3'h0;
      busy_q <= 1'b1;
    end else if (busy_q && tx_ready_i) begin
      // most significant byte leaves first
      sh_q <= {sh_q[55:0], 8'h00}; // see [R07]
      idx_q <= idx_q + 3'h1;
      if (idx_q == 3'h7) begin
        busy_q <= 1'b0;
      end
    end
  end

endmodule

/* storage_cmd_handler.v */
`include "storage_cmd_regs.vh"

module storage_cmd_handler (
  // clock and reset
  input wire clk_i,
  input wire nrst_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // request stream with its frame attributes
  input wire rx_valid_i,
  input wire [7:0] rx_byte_i,
  input wire rx_last_i,
  output wire rx_ready_o,
  input wire rx_udp_i,
  input wire [15:0] rx_udp_port_i,
  input wire [15:0] rx_cluster_i,
  input wire [7:0] rx_dst_ep_i,
  input wire [7:0] rx_src_ep_i,
  input wire rx_bcast_i,
  input wire rx_explicit_i,
  // reply stream with its delivery attributes
  output wire tx_valid_o,
  output wire [7:0] tx_byte_o,
  output wire tx_last_o,
  input wire tx_ready_i,
  output reg [7:0] tx_dst_ep_o,
  output reg tx_udp_o,
  output reg tx_explicit_o,
  // interrupt
  output reg irq_o
);

  // ***************************************************************
  // state and storage
  // ***************************************************************
  localparam ST_IDLE = 3'b001;
  localparam ST_EVAL = 3'b010;
  localparam ST_SEND = 3'b100;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [31:0] ctrl_q;
  reg [`EV_WIDTH-1:0] int_stat_q;
  reg [`EV_WIDTH-1:0] int_mask_q;
  reg [15:0] frame_cnt_q;
  reg [7:0] last_cmd_q;
  reg [7:0] last_status_q;
  reg first_q;
  reg m_udp_q;
  reg [15:0] m_port_q;
  reg [15:0] m_cluster_q;
  reg [7:0] m_dst_ep_q;
  reg [7:0] m_src_ep_q;
  reg m_bcast_q;
  reg m_explicit_q;
  reg [63:0] reply_d;
  reg [7:0] status_d;
  reg [`EV_WIDTH-1:0] ev_d;
  reg load_d;

  wire enable;
  wire frame_mode;
  wire [7:0] app_hdr_len;
  wire rx_take;
  wire [7:0] skip_len;
  wire [63:0] hdr;
  wire hdr_done;
  wire hdr_short;
  wire ser_busy;
  wire [7:0] cmd_code;
  wire [15:0] block_index;
  wire [15:0] byte_offset;
  wire [15:0] payload_len;
  wire addr_ok;
  wire apb_setup;
  wire apb_write;
  wire mapped;

  assign enable = ctrl_q[`CTRL_ENABLE_BIT];
  assign frame_mode = ctrl_q[`CTRL_FRAME_MODE_BIT];
  assign app_hdr_len = ctrl_q[`CTRL_APP_HDR_MSB:`CTRL_APP_HDR_LSB];

  // ***************************************************************
  // helpers
  // ***************************************************************
  // one reply word in wire order; multi-byte fields stay msb first
  function [63:0] pack_reply;
    input [7:0] code;
    input [7:0] status;
    input [15:0] blk;
    input [15:0] ofs;
    input [15:0] len;
    begin
      pack_reply = {code, status, blk, ofs, len}; // see [R10] see [R07]
    end
  endfunction

  function is_mapped;
    input [11:0] addr;
    begin
      is_mapped = (addr == `CTRL_OFS) || (addr == `STATUS_OFS) ||
                  (addr == `INT_STAT_OFS) || (addr == `INT_MASK_OFS) ||
                  (addr == `FRAME_CNT_OFS);
    end
  endfunction

  // ***************************************************************
  // request intake
  // ***************************************************************
  // intake stalls while a frame is judged or a reply is still leaving
  // the cycle after a last byte the header is still unjudged, so hold off a new frame
  assign rx_ready_o = enable && (state_q == ST_IDLE) && !hdr_done;
  assign rx_take = rx_valid_i && rx_ready_o;

  // a first byte uses its own transport flag, never the one left by the last frame
  assign skip_len = (first_q ? rx_udp_i : m_udp_q) ? app_hdr_len : 8'h00; // see [R04]

  hdr_capture u_hdr (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .skip_i(skip_len),
    .take_i(rx_take),
    .byte_i(rx_byte_i),
    .last_i(rx_last_i),
    .hdr_o(hdr),
    .done_o(hdr_done),
    .short_o(hdr_short)
  );

  assign cmd_code = hdr[63:56]; // see [R05]
  assign block_index = hdr[47:32];
  assign byte_offset = hdr[31:16];
  assign payload_len = hdr[15:0]; // see [R06]

  // frame attributes are caught with the first byte of each frame
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      first_q <= 1'b1;
      m_udp_q <= 1'b0;
      m_port_q <= 16'h0000;
      m_cluster_q <= 16'h0000;
      m_dst_ep_q <= 8'h00;
      m_src_ep_q <= 8'h00;
      m_bcast_q <= 1'b0;
      m_explicit_q <= 1'b0;
    end else if (rx_take) begin
      first_q <= rx_last_i;
      if (first_q) begin
        m_udp_q <= rx_udp_i;
        m_port_q <= rx_udp_port_i;
        m_cluster_q <= rx_cluster_i;
        m_dst_ep_q <= rx_dst_ep_i;
        m_src_ep_q <= rx_src_ep_i;
        m_bcast_q <= rx_bcast_i;
        m_explicit_q <= rx_explicit_i;
      end
    end else if (state_q == ST_SEND && !ser_busy) begin
      m_udp_q <= 1'b0;
    end
  end

  // serial frames must target the storage cluster on the vendor endpoint
  assign addr_ok = m_udp_q ? (m_port_q == `STORAGE_UDP_PORT) : // see [R04]
                   (m_cluster_q == `STORAGE_CLUSTER) &&
                   (m_dst_ep_q == `VENDOR_ENDPOINT); // see [R02]

  // ***************************************************************
  // command evaluation
  // ***************************************************************
  always @* begin
    state_d = state_q;
    reply_d = 64'h0000000000000000;
    status_d = `STATUS_OK;
    ev_d = {`EV_WIDTH{1'b0}};
    load_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (hdr_done) begin
          state_d = ST_EVAL;
        end
      end
      ST_EVAL: begin
        state_d = ST_IDLE;
        if (!addr_ok) begin
          ev_d[`EV_ADDR_REJECT] = 1'b1;
        end else if (hdr_short) begin
          ev_d[`EV_SHORT_FRAME] = 1'b1;
        end else if (m_bcast_q) begin
          // broadcast requests are consumed silently
          ev_d[`EV_BCAST_DROP] = 1'b1; // see [R08]
        end else if (cmd_code == `CMD_GEOMETRY_QUERY) begin
          // offset and payload of the query are not checked
          reply_d = pack_reply(`CMD_GEOMETRY_REPLY, `STATUS_OK, // see [R12]
                               `STORAGE_BLOCK_COUNT, `STORAGE_BLOCK_SIZE, // see [R14] see [R01]
                               16'h0000); // see [R15] see [R11]
          load_d = 1'b1;
          state_d = ST_SEND;
        end else begin
          // erase, write and read live elsewhere: refuse with error
          status_d = `STATUS_ERROR; // see [R13]
          reply_d = pack_reply(cmd_code, status_d, block_index, // see [R16]
                               byte_offset, 16'h0000);
          ev_d[`EV_BAD_CMD] = 1'b1;
          load_d = 1'b1;
          state_d = ST_SEND;
        end
      end
      ST_SEND: begin
        if (!ser_busy) begin
          ev_d[`EV_REPLY_DONE] = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      last_cmd_q <= 8'h00;
      last_status_q <= 8'h00;
      frame_cnt_q <= 16'h0000;
      tx_dst_ep_o <= 8'h00;
      tx_udp_o <= 1'b0;
      tx_explicit_o <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == ST_EVAL && addr_ok) begin
        frame_cnt_q <= frame_cnt_q + 16'h0001;
        last_cmd_q <= cmd_code;
      end
      if (load_d) begin
        last_status_q <= status_d;
        // the reply goes back to where the request came from
        tx_dst_ep_o <= m_src_ep_q; // see [R08]
        tx_udp_o <= m_udp_q;
        tx_explicit_o <= frame_mode && !m_udp_q && // see [R09]
                         (m_src_ep_q == `VENDOR_ENDPOINT || m_explicit_q);
      end
    end
  end

  reply_serialiser u_ser (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .load_i(load_d),
    .frame_i(reply_d),
    .busy_o(ser_busy),
    .tx_valid_o(tx_valid_o),
    .tx_byte_o(tx_byte_o),
    .tx_last_o(tx_last_o),
    .tx_ready_i(tx_ready_i)
  );

  // ***************************************************************
  // apb slave and interrupt
  // ***************************************************************
  // zero wait states: read data is fetched in the setup cycle
  assign apb_setup = psel_i && !penable_i;
  assign apb_write = psel_i && penable_i && pwrite_i;
  assign mapped = is_mapped(paddr_i);
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      ctrl_q <= `CTRL_RESET;
      int_mask_q <= `INT_MASK_RESET;
      int_stat_q <= {`EV_WIDTH{1'b0}};
      prdata_o <= 32'h00000000;
      irq_o <= 1'b0;
    end else begin
      if (apb_write && paddr_i == `CTRL_OFS) begin
        ctrl_q <= {16'h0000, pwdata_i[15:8], 6'h00, pwdata_i[1:0]};
      end
      if (apb_write && paddr_i == `INT_MASK_OFS) begin
        int_mask_q <= pwdata_i[`EV_WIDTH-1:0];
      end
      // a new event beats a write-one-to-clear in the same cycle
      if (apb_write && paddr_i == `INT_STAT_OFS) begin
        int_stat_q <= (int_stat_q & ~pwdata_i[`EV_WIDTH-1:0]) | ev_d;
      end else begin
        int_stat_q <= int_stat_q | ev_d;
      end
      irq_o <= |(int_stat_q & int_mask_q);
      if (apb_setup && !pwrite_i) begin
        case (paddr_i)
          `CTRL_OFS: prdata_o <= ctrl_q;
          `STATUS_OFS: prdata_o <= {15'h0000, last_status_q[0], last_cmd_q,
                                    5'h00, state_q};
          `INT_STAT_OFS: prdata_o <= {27'h0000000, int_stat_q};
          `INT_MASK_OFS: prdata_o <= {27'h0000000, int_mask_q};
          `FRAME_CNT_OFS: prdata_o <= {16'h0000, frame_cnt_q};
          default: prdata_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

/* storage_cmd_handler_asserts.sv */
module storage_cmd_handler_chk (
  // clock and reset
  input wire clk_i,
  input wire nrst_i,
  // watched ports
  input wire psel_i,
  input wire penable_i,
  input wire pslverr_o,
  input wire rx_valid_i,
  input wire rx_last_i,
  input wire rx_bcast_i,
  input wire rx_ready_o,
  input wire tx_valid_o,
  input wire [7:0] tx_byte_o,
  input wire tx_last_o,
  input wire tx_ready_i,
  input wire tx_udp_o,
  input wire tx_explicit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************
  // reply byte position, wraps after the eighth byte
  // ************
  logic [2:0] pos_q;
  always @(posedge clk_i) begin
    if (!nrst_i) pos_q <= 3'h0;
    else if (tx_valid_o && tx_ready_i) pos_q <= pos_q + 3'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  err_access_a: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("slave error outside access phase");
  last_byte_a: assert property (tx_valid_o |-> tx_last_o == (pos_q == 3'h7))
    else $error("last flag not on eighth byte");
  status_rsvd_a: assert property (
    tx_valid_o && pos_q == 3'h1 |-> tx_byte_o[7:1] == 7'h00)
    else $error("reserved status bits set");
  len_zero_a: assert property (
    tx_valid_o && pos_q[2:1] == 2'h3 |-> tx_byte_o == 8'h00)
    else $error("reply length not zero");
  hold_byte_a: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
    else $error("reply byte dropped while stalled");
  reply_time_a: assert property (
    $rose(tx_valid_o) |-> $past(rx_valid_i && rx_ready_o && rx_last_i, 3))
    else $error("reply not three cycles after last byte");
  bcast_quiet_a: assert property (
    rx_valid_i && rx_ready_o && rx_last_i && rx_bcast_i |=> !tx_valid_o [*4])
    else $error("reply to broadcast");
  busy_block_a: assert property (tx_valid_o |-> !rx_ready_o)
    else $error("request taken during reply");
  ready_drop_a: assert property (
    rx_valid_i && rx_ready_o && rx_last_i |=> !rx_ready_o)
    else $error("byte taken while header is judged");
  udp_plain_a: assert property (tx_valid_o && tx_udp_o |-> !tx_explicit_o)
    else $error("network reply marked explicit");
endmodule

bind storage_cmd_handler storage_cmd_handler_chk chk (.clk_i, .nrst_i, .psel_i, .penable_i,
  .pslverr_o, .rx_valid_i, .rx_last_i, .rx_bcast_i, .rx_ready_o, .tx_valid_o, .tx_byte_o,
  .tx_last_o, .tx_ready_i, .tx_udp_o, .tx_explicit_o);

/* storage_requester.sv */
module storage_requester (
  // clock
  input wire logic clk_i,
  // request stream
  output logic rx_valid_o = 1'b0,
  output logic [7:0] rx_byte_o = 8'h00,
  output logic rx_last_o = 1'b0,
  input wire logic rx_ready_i,
  // reply stream
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_byte_i,
  output logic tx_ready_o,
  input wire logic slow_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tog_q = 1'b0;
  logic [63:0] rep = 64'h0;
  int n_rep = 0;
  // a slow sink takes a byte only every other cycle
  assign tx_ready_o = !slow_i || tog_q;
  always @(posedge clk_i) begin
    tog_q <= !tog_q;
    if (tx_valid_i && tx_ready_o) begin
      rep <= {rep[55:0], tx_byte_i};
      n_rep <= n_rep + 1;
    end
  end
  // ************
  // one request frame, app header first when skip is nonzero
  // ************
  task send(input logic [7:0] code, input logic [15:0] blk, ofs, input int skip);
    logic [7:0] b[$];
    b = {};
    repeat (skip) b.push_back(8'h5a);
    b = {b, code, 8'h00, blk[15:8], blk[7:0]};
    b = {b, ofs[15:8], ofs[7:0], 8'h00, 8'h00};
    foreach (b[i]) begin
      rx_valid_o <= 1'b1;
      rx_byte_o <= b[i];
      rx_last_o <= (i == b.size() - 1);
      // only the bench timeout ends a stalled intake
      do begin
        @(posedge clk_i);
      end while (rx_ready_i !== 1'b1);
    end
    rx_valid_o <= 1'b0;
    rx_last_o <= 1'b0;
    // released line must not keep showing the last byte
    rx_byte_o <= ~rx_byte_o;
  endtask
endmodule

/* storage_cmd_handler_tb.sv */
module storage_cmd_handler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, nrst_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h0;
  logic [31:0] pwdata_i = 32'h0, rdat, prdata_o;
  logic [15:0] rx_udp_port_i = 16'h0bee, rx_cluster_i = 16'h0023;
  logic [7:0] rx_dst_ep_i = 8'he6, rx_src_ep_i = 8'he6, rx_byte_i, tx_byte_o, tx_dst_ep_o;
  logic rx_valid_i, rx_last_i, tx_ready_i, slow_i = 1'b0, rx_udp_i = 1'b0, rx_bcast_i = 1'b0;
  logic rx_explicit_i = 1'b0, rx_ready_o, tx_valid_o, tx_last_o, tx_udp_o, tx_explicit_o;
  logic irq_o, pready_o, pslverr_o, err;
  int failures = 0, n_compared = 0, cyc = 0, n0;
  typedef struct {logic [7:0] code; logic [15:0] blk, ofs; logic [7:0] src;
    logic xin, slow, expl; logic [63:0] rep;} row_t;
  row_t rows [4] = '{
    '{8'h00, 16'h0000, 16'h0000, 8'he6, 1'b0, 1'b0, 1'b1, 64'h800000a010000000},
    '{8'h00, 16'h0000, 16'h0000, 8'h41, 1'b0, 1'b1, 1'b0, 64'h800000a010000000},
    '{8'h05, 16'h002a, 16'h0200, 8'h41, 1'b1, 1'b0, 1'b1, 64'h0501002a02000000},
    '{8'h7f, 16'hffff, 16'h0fff, 8'h12, 1'b0, 1'b1, 1'b0, 64'h7f01ffff0fff0000}};
  storage_cmd_handler uut (.clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .rx_valid_i, .rx_byte_i, .rx_last_i, .rx_ready_o, .rx_udp_i,
    .rx_udp_port_i, .rx_cluster_i, .rx_dst_ep_i, .rx_src_ep_i, .rx_bcast_i, .rx_explicit_i,
    .tx_valid_o, .tx_byte_o, .tx_last_o, .tx_ready_i, .tx_dst_ep_o, .tx_udp_o, .tx_explicit_o,
    .irq_o);
  storage_requester req (.clk_i, .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i),
    .rx_last_o(rx_last_i), .rx_ready_i(rx_ready_o), .tx_valid_i(tx_valid_o),
    .tx_byte_i(tx_byte_o), .tx_ready_o(tx_ready_i), .slow_i);
  always #5 clk_i = !clk_i;
  // ************
  // shared tasks
  // ************
  task summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  task chk(input logic ok, input string m);
    n_compared++;
    if (!ok) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rdat = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task wait_rep();
    int k;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (req.n_rep != n0 + 8 && k < 300);
    chk(k < 300, "reply missing");
    @(posedge clk_i);
  endtask
  task quiet(input string m);
    repeat (20) @(posedge clk_i);
    chk(req.n_rep == n0, m);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    foreach (rows[i]) begin
      rx_src_ep_i <= rows[i].src;
      rx_explicit_i <= rows[i].xin;
      slow_i <= rows[i].slow;
      n0 = req.n_rep;
      req.send(rows[i].code, rows[i].blk, rows[i].ofs, 0);
      wait_rep();
      chk(req.rep[63:48] === rows[i].rep[63:48], "reply head");
      chk(req.rep[47:0] === rows[i].rep[47:0], "reply fields");
      chk(tx_dst_ep_o === rows[i].src, "reply endpoint");
      chk(tx_explicit_o === rows[i].expl, "explicit delivery");
      $display("row %0d done", i);
    end
    apb(1'b0, 12'h004, 32'h0);
    chk(rdat === 32'h00017f01, "status after refused command");
    apb(1'b1, 12'h000, 32'h00000203);
    rx_udp_i <= 1'b1;
    n0 = req.n_rep;
    req.send(8'h00, 16'h0000, 16'h0000, 2);
    wait_rep();
    chk(req.rep === rows[0].rep && tx_udp_o === 1'b1, "udp reply");
    chk(tx_explicit_o === 1'b0, "udp reply marked explicit");
    rx_udp_port_i <= 16'h0bef;
    n0 = req.n_rep;
    req.send(8'h00, 16'h0000, 16'h0000, 2);
    quiet("wrong port answered");
    rx_udp_port_i <= 16'h0bee;
    // no application header: eight bytes where ten are needed
    req.send(8'h00, 16'h0000, 16'h0000, 0);
    quiet("short frame answered");
    rx_udp_i <= 1'b0;
    $display("udp test done");
    rx_bcast_i <= 1'b1;
    n0 = req.n_rep;
    req.send(8'h00, 16'h0000, 16'h0000, 0);
    rx_bcast_i <= 1'b0;
    quiet("broadcast answered");
    apb(1'b0, 12'h008, 32'h0);
    chk(rdat[2] === 1'b1 && rdat[4] === 1'b1 && irq_o === 1'b0, "drop events or masked irq");
    apb(1'b1, 12'h00c, 32'h00000004);
    repeat (2) @(posedge clk_i);
    chk(irq_o === 1'b1, "irq not raised");
    apb(1'b1, 12'h008, 32'h00000004);
    repeat (2) @(posedge clk_i);
    chk(irq_o === 1'b0, "irq not cleared");
    $display("interrupt test done");
    // clear every event first so the reject bit can only come from this frame
    apb(1'b1, 12'h008, 32'h0000001f);
    rx_cluster_i <= 16'h0024;
    n0 = req.n_rep;
    req.send(8'h00, 16'h0000, 16'h0000, 0);
    quiet("wrong cluster answered");
    rx_cluster_i <= 16'h0023;
    apb(1'b0, 12'h008, 32'h0);
    chk(rdat[3] === 1'b1 && rdat[4] === 1'b0, "reject event");
    apb(1'b0, 12'h100, 32'h0);
    chk(err === 1'b1 && rdat === 32'h0, "unmapped read");
    apb(1'b0, 12'h010, 32'h0);
    chk(rdat === 32'h00000007, "frame count");
    $display("reject test done");
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    apb(1'b0, 12'h000, 32'h0);
    chk(rdat === 32'h00000003, "control reset value");
    apb(1'b0, 12'h00c, 32'h0);
    chk(rdat === 32'h0 && irq_o === 1'b0, "mask reset value");
    $display("reset test done");
    summarize();
  end
endmodule
